/* common/hdb_pkg.sv */
// constants, types and helpers for the data-link byte-count block
package hdb_pkg;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int CNT_W = 7;

    localparam logic [ADDR_W-1:0] ADDR_TX_COUNT = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_RX_COUNT = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 3'h4;

    localparam int SEL_BIT = 7;
    localparam int CTL_MODE_BIT = 0;
    localparam int CTL_CHECK_BIT = 1;
    localparam int INT_TX_EOT_BIT = 0;
    localparam int INT_RX_EOT_BIT = 1;
    localparam int INT_W = 2;

    localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RESET = 7'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
    localparam logic [INT_W-1:0] INT_RESET = 2'h0;
    localparam logic [1:0] BUSY_RESET = 2'h0;

    typedef enum logic [1:0] {
        HDB_TX_IDLE = 2'b01,
        HDB_TX_SEND = 2'b10
    } hdb_tx_state_t;

    // true on the step that completes the programmed repetitions
    function automatic logic count_hit(input logic [CNT_W-1:0] cnt,
                                       input logic [CNT_W-1:0] limit);
        count_hit = (limit != CNT_RESET) && ((cnt + CNT_ONE) == limit);
    endfunction : count_hit

    // index of the transmit buffer software should fill next
    function automatic logic next_free(input logic [1:0] busy, input logic last);
        if (busy[0] && !busy[1]) begin
            next_free = 1'b1;
        end else if (busy[1] && !busy[0]) begin
            next_free = 1'b0;
        end else begin
            next_free = ~last;
        end
    endfunction : next_free

endpackage : hdb_pkg

/* verif/hdb_far_end.sv */
// far-end model: transmit engine and remote message source
module hdb_far_end (
    input wire logic clock,
    input wire logic nrst,
    input wire logic tx_req,
    input wire logic slow,
    output logic tx_msg_done = 1'b0,
    output logic rx_msg_done = 1'b0,
    output logic rx_msg_buf = 1'b0,
    output logic [hdb_pkg::CNT_W-1:0] rx_msg_len = 7'h00,
    output int sent = 0
);
    timeunit 1ns;
    timeprecision 1ns;
    import hdb_pkg::*;
    logic [3:0] wait_ff = 4'h0;
    // one message taken per gap while requested
    always @(posedge clock) begin
        if (!nrst || !tx_req) begin
            wait_ff <= 4'h0;
            tx_msg_done <= 1'b0;
        end else if (wait_ff == (slow ? 4'h5 : 4'h1)) begin
            wait_ff <= 4'h0;
            tx_msg_done <= 1'b1;
            sent <= sent + 1;
        end else begin
            wait_ff <= wait_ff + 4'h1;
            tx_msg_done <= 1'b0;
        end
    end
    task automatic send_rx(input logic b, input logic [CNT_W-1:0] n);
        @(posedge clock);
        rx_msg_done <= 1'b1;
        rx_msg_buf <= b;
        rx_msg_len <= n;
        @(posedge clock);
        rx_msg_done <= 1'b0;
        // stale qualifiers are not held
        rx_msg_buf <= ~b;
        rx_msg_len <= ~n;
    endtask : send_rx
endmodule : hdb_far_end

/* verif/hdb_properties.sv */
// port-level assertion checker for the byte-count block
module hdb_chk (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [hdb_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [hdb_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [hdb_pkg::DATA_W-1:0] reg_rdata,
    input wire logic tx_req,
    input wire logic tx_buf,
    input wire logic tx_mode_msg,
    input wire logic tx_append_check,
    input wire logic [hdb_pkg::CNT_W-1:0] tx_length,
    input wire logic tx_msg_done,
    input wire logic rx_msg_done,
    input wire logic rx_msg_buf,
    input wire logic [hdb_pkg::CNT_W-1:0] rx_msg_len,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import hdb_pkg::*;
    logic [CNT_W-1:0] dcnt_ff;
    logic [CNT_W-1:0] nxt_dcnt;
    // done pulses within one transmission
    always_comb begin
        nxt_dcnt = tx_req ? dcnt_ff + {6'h00, tx_msg_done} : CNT_RESET;
    end
    always_ff @(posedge clock) begin
        if (!nrst) begin
            dcnt_ff <= CNT_RESET;
        end else begin
            dcnt_ff <= nxt_dcnt;
        end
    end
    default clocking dflt @(posedge clock); endclocking
    default disable iff (!nrst);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_buf_steady: assert property (tx_req && $past(tx_req) |-> $stable(tx_buf))
        else $error("buffer changed while sending");
    a_end_on_done: assert property ($fell(tx_req) && $past(nrst) |-> $past(tx_msg_done))
        else $error("send ended without done");
    a_count_reps: assert property ($fell(tx_req) && !tx_mode_msg |-> dcnt_ff == tx_length)
        else $error("wrong repetition count");
    a_zero_forever: assert property (tx_req && !tx_mode_msg && tx_length == CNT_RESET
        |=> tx_req) else $error("zero count send ended");
    a_msg_single: assert property (tx_req && tx_msg_done && tx_mode_msg |=> !tx_req)
        else $error("message send not ended");
    a_check_msg: assert property (tx_append_check |-> tx_mode_msg)
        else $error("check append in bit mode");
    a_rx_pointer: assert property (rx_msg_done ##1 (!rx_msg_done && !reg_wr) ##1 (reg_rd
        && reg_addr == ADDR_RX_COUNT && !reg_wr && !rx_msg_done)
        |=> reg_rdata[SEL_BIT] == $past(rx_msg_buf, 3))
        else $error("receive pointer wrong");
endmodule : hdb_chk

bind hdb_top hdb_chk i_chk (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_req(tx_req), .tx_buf(tx_buf), .tx_mode_msg(tx_mode_msg),
    .tx_append_check(tx_append_check), .tx_length(tx_length), .tx_msg_done(tx_msg_done),
    .rx_msg_done(rx_msg_done), .rx_msg_buf(rx_msg_buf), .rx_msg_len(rx_msg_len), .irq(irq));

/* verif/testbench.sv */
// self-checking bench for the byte-count block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import hdb_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 3'h0;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic slow = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [CNT_W-1:0] tx_length;
    logic [CNT_W-1:0] rx_msg_len;
    logic tx_req, tx_buf, tx_mode_msg, tx_append_check, irq;
    logic tx_msg_done, rx_msg_done, rx_msg_buf;
    int sent;
    int s;
    int mismatches = 0;
    int compares = 0;

    always #25 clock = ~clock;

    hdb_top i_dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_req(tx_req),
        .tx_buf(tx_buf), .tx_mode_msg(tx_mode_msg), .tx_append_check(tx_append_check),
        .tx_length(tx_length), .tx_msg_done(tx_msg_done), .rx_msg_done(rx_msg_done),
        .rx_msg_buf(rx_msg_buf), .rx_msg_len(rx_msg_len), .irq(irq));
    hdb_far_end i_far (.clock(clock), .nrst(nrst), .tx_req(tx_req), .slow(slow),
        .tx_msg_done(tx_msg_done), .rx_msg_done(rx_msg_done), .rx_msg_buf(rx_msg_buf),
        .rx_msg_len(rx_msg_len), .sent(sent));

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wait_req(input logic lvl);
        int n = 0;
        while (tx_req !== lvl && n < 400) begin
            @(negedge clock);
            n++;
        end
        if (tx_req !== lvl) begin
            check("tx_req wait", 8'(lvl), 8'(tx_req));
            complete_run();
        end
    endtask : wait_req

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input string what);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        check(what, exp, reg_rdata);
    endtask : rd

    task automatic do_reset(input int cycles);
        nrst <= 1'b0;
        repeat (cycles) @(posedge clock);
        nrst <= 1'b1;
    endtask : do_reset

    task automatic t_regs();
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), 8'h00, "reset value");
        end
        wr(ADDR_INT_MASK, 8'h03);
        wr(3'h7, 8'hff);
        rd(3'h7, 8'h00, "unmapped");
        rd(ADDR_INT_MASK, 8'h03, "mask");
        $display("test regs done");
    endtask : t_regs

    task automatic t_bit();
        slow <= 1'b1;
        s = sent;
        wr(ADDR_TX_COUNT, 8'h02);
        wait_req(1'b1);
        check("buffer 0", 8'h00, 8'(tx_buf));
        rd(ADDR_TX_COUNT, 8'h82, "next free");
        wr(ADDR_TX_COUNT, 8'h02);
        wr(ADDR_TX_COUNT, 8'h82);
        wait_req(1'b0);
        check("reps 0", 8'h02, 8'(sent - s));
        wait_req(1'b1);
        check("buffer 1", 8'h01, 8'(tx_buf));
        wait_req(1'b0);
        check("reps 1", 8'h04, 8'(sent - s));
        repeat (20) @(negedge clock);
        check("refused", 8'h00, 8'(tx_req));
        rd(ADDR_INT_STATUS, 8'h01, "tx eot");
        check("irq set", 8'h01, 8'(irq));
        wr(ADDR_INT_STATUS, 8'h01);
        rd(ADDR_INT_STATUS, 8'h00, "cleared");
        check("irq clear", 8'h00, 8'(irq));
        $display("test bit mode done");
    endtask : t_bit

    task automatic t_zero();
        slow <= 1'b0;
        wr(ADDR_TX_COUNT, 8'h00);
        wait_req(1'b1);
        repeat (300) @(negedge clock);
        check("endless", 8'h01, 8'(tx_req));
        do_reset(2);
        @(negedge clock);
        check("reset req", 8'h00, 8'(tx_req));
        $display("test zero count done");
    endtask : t_zero

    task automatic t_msg();
        wr(ADDR_INT_MASK, 8'h03);
        wr(ADDR_CONTROL, 8'h03);
        rd(ADDR_CONTROL, 8'h03, "control");
        check("mode", 8'h01, 8'(tx_mode_msg));
        check("append", 8'h01, 8'(tx_append_check));
        s = sent;
        wr(ADDR_TX_COUNT, 8'h0a);
        wait_req(1'b1);
        check("length", 8'h0a, 8'(tx_length));
        wait_req(1'b0);
        check("one message", 8'h01, 8'(sent - s));
        i_far.send_rx(1'b1, 7'h25);
        rd(ADDR_RX_COUNT, 8'ha5, "rx length");
        i_far.send_rx(1'b0, 7'h11);
        rd(ADDR_RX_COUNT, 8'h11, "rx length");
        rd(ADDR_INT_STATUS, 8'h01, "msg status");
        wr(ADDR_CONTROL, 8'h02);
        rd(ADDR_INT_STATUS, 8'h01, "msg status");
        check("append off", 8'h00, 8'(tx_append_check));
        $display("test message mode done");
    endtask : t_msg

    task automatic t_rx();
        wr(ADDR_INT_STATUS, 8'h03);
        wr(ADDR_RX_COUNT, 8'h02);
        i_far.send_rx(1'b1, 7'h33);
        rd(ADDR_RX_COUNT, 8'h82, "rx pointer");
        rd(ADDR_INT_STATUS, 8'h00, "rx early");
        i_far.send_rx(1'b0, 7'h33);
        rd(ADDR_INT_STATUS, 8'h02, "rx eot");
        check("irq rx", 8'h01, 8'(irq));
        wr(ADDR_INT_MASK, 8'h01);
        rd(ADDR_INT_MASK, 8'h01, "mask");
        check("irq masked", 8'h00, 8'(irq));
        wr(ADDR_INT_STATUS, 8'h02);
        wr(ADDR_RX_COUNT, 8'h00);
        repeat (3) i_far.send_rx(1'b0, 7'h01);
        rd(ADDR_INT_STATUS, 8'h00, "rx endless");
        $display("test receive done");
    endtask : t_rx

    initial begin
        do_reset(10);
        t_regs();
        t_bit();
        t_zero();
        t_msg();
        t_rx();
        complete_run();
    end
endmodule : testbench

/* verilog/hdb_irq.sv */
// sticky event status, mask and level interrupt
module hdb_irq
    import hdb_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [hdb_pkg::INT_W-1:0] events,
    input wire logic clear_wr,
    input wire logic mask_wr,
    input wire logic [hdb_pkg::INT_W-1:0] wdata,
    output logic [hdb_pkg::INT_W-1:0] status,
    output logic [hdb_pkg::INT_W-1:0] mask,
    output logic irq
);
    logic [INT_W-1:0] status_ff;
    logic [INT_W-1:0] mask_ff;
    logic irq_ff;
    logic [INT_W-1:0] nxt_status;
    logic [INT_W-1:0] nxt_mask;
    logic nxt_irq;

    always_comb begin
        nxt_status = status_ff;
        if (clear_wr) begin
            nxt_status = status_ff & ~wdata;
        end
        // set wins over clear
        nxt_status = nxt_status | events;
        nxt_mask = mask_wr ? wdata : mask_ff;
        nxt_irq = |(nxt_status & nxt_mask);
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            status_ff <= INT_RESET;
            mask_ff <= INT_RESET;
            irq_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
            irq_ff <= nxt_irq;
        end
    end

    assign status = status_ff;
    assign mask = mask_ff;
    assign irq = irq_ff;
endmodule : hdb_irq

/* verilog/hdb_rep_counter.sv */
// repetition counter for bit-oriented messages
module hdb_rep_counter
    import hdb_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic clear,
    input wire logic step,
    input wire logic [hdb_pkg::CNT_W-1:0] limit,
    output logic hit
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    always_comb begin
        hit = step && count_hit(cnt_ff, limit);
        nxt_cnt = cnt_ff;
        if (clear || hit) begin
            nxt_cnt = CNT_RESET;
        end else if (step) begin
            nxt_cnt = cnt_ff + CNT_ONE;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cnt_ff <= CNT_RESET;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule : hdb_rep_counter

/* verilog/hdb_top.sv */
// byte-count and buffer-select logic of the second data-link controller
module hdb_top
    import hdb_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [hdb_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [hdb_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [hdb_pkg::DATA_W-1:0] reg_rdata,
    output logic tx_req,
    output logic tx_buf,
    output logic tx_mode_msg,
    output logic tx_append_check,
    output logic [hdb_pkg::CNT_W-1:0] tx_length,
    input wire logic tx_msg_done,
    input wire logic rx_msg_done,
    input wire logic rx_msg_buf,
    input wire logic [hdb_pkg::CNT_W-1:0] rx_msg_len,
    output logic irq
);
    import hdb_pkg::*;

    // register state
    logic [CNT_W-1:0] tx_message_count_ff;
    logic [CNT_W-1:0] rx_message_count_ff;
    logic rx_latest_buffer_pointer_ff;
    logic signaling_type_select_ff;
    logic tx_check_append_enable_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [CNT_W-1:0] nxt_tx_message_count;
    logic [CNT_W-1:0] nxt_rx_message_count;
    logic nxt_rx_latest_buffer_pointer;
    logic nxt_signaling_type_select;
    logic nxt_tx_check_append_enable;
    logic [DATA_W-1:0] nxt_rdata;

    // transmit sequencing state
    hdb_tx_state_t state_ff;
    hdb_tx_state_t nxt_state;
    logic [1:0] busy_ff;
    logic [1:0] nxt_busy;
    logic tx_buf_ff;
    logic nxt_tx_buf;
    logic last_sel_ff;
    logic nxt_last_sel;
    logic tx_req_ff;
    logic nxt_tx_req;
    logic tx_mode_msg_ff;
    logic tx_append_ff;
    logic [CNT_W-1:0] tx_length_ff;

    // decode and events
    logic wr_tx;
    logic wr_rx;
    logic wr_ctl;
    logic wr_stat;
    logic wr_mask;
    logic wr_sel;
    logic tx_rep_clear;
    logic tx_rep_step;
    logic tx_rep_hit;
    logic rx_rep_step;
    logic rx_rep_hit;
    logic tx_eot_evt;
    logic rx_eot_evt;
    logic [INT_W-1:0] int_events;
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_mask;
    logic msg_mode;

    assign wr_tx = reg_wr && (reg_addr == ADDR_TX_COUNT);
    assign wr_rx = reg_wr && (reg_addr == ADDR_RX_COUNT);
    assign wr_ctl = reg_wr && (reg_addr == ADDR_CONTROL);
    assign wr_stat = reg_wr && (reg_addr == ADDR_INT_STATUS);
    assign wr_mask = reg_wr && (reg_addr == ADDR_INT_MASK);
    assign wr_sel = reg_wdata[SEL_BIT];
    assign msg_mode = signaling_type_select_ff;

    // control and count registers
    always_comb begin
        nxt_tx_message_count = tx_message_count_ff;
        nxt_rx_message_count = rx_message_count_ff;
        nxt_rx_latest_buffer_pointer = rx_latest_buffer_pointer_ff;
        nxt_signaling_type_select = signaling_type_select_ff;
        nxt_tx_check_append_enable = tx_check_append_enable_ff;
        if (wr_tx) begin
            nxt_tx_message_count = reg_wdata[CNT_W-1:0];
        end
        if (wr_rx) begin
            nxt_rx_message_count = reg_wdata[CNT_W-1:0];
            nxt_rx_latest_buffer_pointer = reg_wdata[SEL_BIT];
        end
        if (wr_ctl) begin
            nxt_signaling_type_select = reg_wdata[CTL_MODE_BIT];
            nxt_tx_check_append_enable = reg_wdata[CTL_CHECK_BIT];
        end
        if (rx_msg_done) begin
            nxt_rx_latest_buffer_pointer = rx_msg_buf;
            if (msg_mode) begin
                nxt_rx_message_count = rx_msg_len;
            end
        end
    end

    // read mux, data valid the cycle after the strobe
    always_comb begin
        nxt_rdata = BYTE_RESET;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_TX_COUNT: begin
                    nxt_rdata = {next_free(busy_ff, last_sel_ff), tx_message_count_ff};
                end
                ADDR_RX_COUNT: begin
                    nxt_rdata = {rx_latest_buffer_pointer_ff, rx_message_count_ff};
                end
                ADDR_CONTROL: begin
                    nxt_rdata = BYTE_RESET;
                    nxt_rdata[CTL_MODE_BIT] = signaling_type_select_ff;
                    nxt_rdata[CTL_CHECK_BIT] = tx_check_append_enable_ff;
                end
                ADDR_INT_STATUS: begin
                    nxt_rdata = {{(DATA_W-INT_W){1'b0}}, int_status};
                end
                ADDR_INT_MASK: begin
                    nxt_rdata = {{(DATA_W-INT_W){1'b0}}, int_mask};
                end
                default: begin
                    nxt_rdata = BYTE_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            tx_message_count_ff <= CNT_RESET;
            rx_message_count_ff <= CNT_RESET;
            rx_latest_buffer_pointer_ff <= 1'b0;
            signaling_type_select_ff <= 1'b0;
            tx_check_append_enable_ff <= 1'b0;
            rdata_ff <= BYTE_RESET;
        end else begin
            tx_message_count_ff <= nxt_tx_message_count;
            rx_message_count_ff <= nxt_rx_message_count;
            rx_latest_buffer_pointer_ff <= nxt_rx_latest_buffer_pointer;
            signaling_type_select_ff <= nxt_signaling_type_select;
            tx_check_append_enable_ff <= nxt_tx_check_append_enable;
            rdata_ff <= nxt_rdata;
        end
    end

    // transmit buffer sequencing
    always_comb begin
        nxt_state = state_ff;
        nxt_busy = busy_ff;
        nxt_tx_buf = tx_buf_ff;
        nxt_last_sel = last_sel_ff;
        tx_rep_clear = 1'b0;
        tx_eot_evt = 1'b0;
        // selecting a busy buffer is refused
        if (wr_tx && !busy_ff[wr_sel]) begin
            nxt_busy[wr_sel] = 1'b1;
            nxt_last_sel = wr_sel;
        end
        unique case (state_ff)
            HDB_TX_IDLE: begin
                if (|busy_ff) begin
                    nxt_state = HDB_TX_SEND;
                    nxt_tx_buf = busy_ff[0] ? 1'b0 : 1'b1;
                    tx_rep_clear = 1'b1;
                end
            end
            HDB_TX_SEND: begin
                // finish after count or one message
                if (tx_msg_done && (msg_mode || tx_rep_hit)) begin
                    nxt_busy[tx_buf_ff] = 1'b0;
                    nxt_state = HDB_TX_IDLE;
                    tx_eot_evt = 1'b1;
                end
            end
            default: begin
                nxt_state = HDB_TX_IDLE;
            end
        endcase
        nxt_tx_req = (nxt_state == HDB_TX_SEND);
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_ff <= HDB_TX_IDLE;
            busy_ff <= BUSY_RESET;
            tx_buf_ff <= 1'b0;
            last_sel_ff <= 1'b1;
            tx_req_ff <= 1'b0;
            tx_mode_msg_ff <= 1'b0;
            tx_append_ff <= 1'b0;
            tx_length_ff <= CNT_RESET;
        end else begin
            state_ff <= nxt_state;
            busy_ff <= nxt_busy;
            tx_buf_ff <= nxt_tx_buf;
            last_sel_ff <= nxt_last_sel;
            tx_req_ff <= nxt_tx_req;
            tx_mode_msg_ff <= nxt_signaling_type_select;
            tx_append_ff <= nxt_signaling_type_select && nxt_tx_check_append_enable;
            tx_length_ff <= nxt_tx_message_count;
        end
    end

    assign tx_rep_step = tx_msg_done && (state_ff == HDB_TX_SEND) && !msg_mode;

    hdb_rep_counter u_tx_rep (
        .clock(clock),
        .nrst(nrst),
        .clear(tx_rep_clear),
        .step(tx_rep_step),
        .limit(tx_message_count_ff),
        .hit(tx_rep_hit)
    );

    // count received repetitions, zero never hits
    assign rx_rep_step = rx_msg_done && !msg_mode;
    assign rx_eot_evt = rx_rep_hit;

    hdb_rep_counter u_rx_rep (
        .clock(clock),
        .nrst(nrst),
        .clear(wr_rx),
        .step(rx_rep_step),
        .limit(rx_message_count_ff),
        .hit(rx_rep_hit)
    );

    always_comb begin
        int_events = INT_RESET;
        int_events[INT_TX_EOT_BIT] = tx_eot_evt;
        int_events[INT_RX_EOT_BIT] = rx_eot_evt;
    end

    hdb_irq u_irq (
        .clock(clock),
        .nrst(nrst),
        .events(int_events),
        .clear_wr(wr_stat),
        .mask_wr(wr_mask),
        .wdata(reg_wdata[INT_W-1:0]),
        .status(int_status),
        .mask(int_mask),
        .irq(irq)
    );

    assign reg_rdata = rdata_ff;
    assign tx_req = tx_req_ff;
    assign tx_buf = tx_buf_ff;
    assign tx_mode_msg = tx_mode_msg_ff;
    assign tx_append_check = tx_append_ff;
    assign tx_length = tx_length_ff;
endmodule : hdb_top
